// ==== hw/pcr_pkg.sv ====
// package: constants for the phy start-up configuration and reset block
package pcr_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int REG_HOLD_US = 1000; // register blackout after hardware reset, 1 ms
	localparam int REG_HOLD_CYC = (CLK_HZ / 1000000) * REG_HOLD_US;
	localparam int SRST_CYC = 16; // duration of a software reset sequence
	localparam int MDC_MAX_HZ = 8000000; // upper limit of the far side's management clock
	// ---------------------------------------------------------------
	// wishbone register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADV = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_STRAP = 8'h0C;
	// ---------------------------------------------------------------
	// control word bit positions
	// ---------------------------------------------------------------
	localparam int B_SRST = 15;
	localparam int B_SPEED = 13;
	localparam int B_ANEG = 12;
	localparam int B_SPD = 11;
	localparam int B_FDX = 8;
	// advertisement bit positions, 100 full down to 10 half
	localparam int B_A100F = 8;
	localparam int B_A100H = 7;
	localparam int B_A10F = 6;
	localparam int B_A10H = 5;
	localparam logic [15:0] ADV_RESET = 16'h0001;
	// status bit positions
	localparam int S_READY = 0;
	localparam int S_PINCTL = 1;
	localparam int S_FORCED = 2;
	localparam int S_ANRUN = 3;
	localparam int S_PORTUP = 4;
	localparam int S_SRST = 5;
	typedef enum logic [3:0] {
		PCR_HOLD = 4'h1,
		PCR_RUN = 4'h2,
		PCR_SRST = 4'h4,
		PCR_DOWN = 4'h8
	} pcr_state_e;
endpackage

// ==== hw/pcr_strap.sv ====
// strap capture: latches the three config pins when reset is released
`timescale 1ns/1ns
`default_nettype none
module pcr_strap
	import pcr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [2:0] pins_in,
	output logic [2:0] strap_out
);
	logic was_reset;
	logic [2:0] next_strap;
	// ---------------------------------------------------------------
	// capture on the first edge after reset falls
	// ---------------------------------------------------------------
	// pins are caught by a clocked process, never under the reset itself
	always_comb begin
		next_strap = strap_out;
		if (was_reset && !reset_in) begin
			next_strap = pins_in;
		end
	end
	always_ff @(posedge clk_in) begin
		was_reset <= reset_in;
		strap_out <= next_strap;
	end
endmodule
`default_nettype wire

// ==== hw/pcr_top.sv ====
// top: start-up configuration, reset and power-down control of the transceiver
// Contract
// - power-on, reset and link failure consult config bits for speed.
// - in managed mode pins only give defaults; writes then govern.
// - in pin-control mode management writes are blocked.
// - in pin-control mode pins are sampled at reset into registers.
// - forced 100/10 full/half or autonegotiation supported in both modes.
// - forced configuration starts port at once without negotiation.
// - autonegotiation enabled starts negotiation and parallel detection.
// - power-down pin stops port, floats outputs, drops pulls, refuses access.
// - software power-down bit stops port, registers stay accessible.
// - hardware reset captures enable_bit_a and speed from the pins.
// - software reset restores the latched pin values without resampling.
// - registers invalid for one millisecond after hardware reset release.
// - registers readable during soft reset; reset bit clears on completion.
// - configuration comes from three led driver pins.
// - pin1 low clears enable_bit_a; pin2 sets speed, pin3 sets duplex.
// - pin1 high sets enable_bit_a and speed, pin3 duplex, advertisement per pins.
// - disable pin high blocks management access, selecting pin control; the code blocks writes only, reads are still answered.
`timescale 1ns/1ns
`default_nettype none
module pcr_top
	import pcr_pkg::*;
#(
	parameter int HOLD_CYC = REG_HOLD_CYC
)
(
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic [2:0] LED_CONFIG_PIN_IN,
	input wire logic POWER_DOWN_PIN_IN,
	input wire logic MGMT_PORT_DISABLE_PIN_IN,
	input wire logic LINK_FAIL_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	output logic WB_ERR_OUT,
	output logic PORT_ENABLE_OUT,
	output logic FORCED_START_OUT,
	output logic ANEG_START_OUT,
	output logic SPEED_100_OUT,
	output logic FULL_DUPLEX_OUT,
	output logic CLOCK_RUN_OUT,
	output logic OUTPUT_HIZ_OUT,
	output logic PULLS_ENABLE_OUT
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [2:0] strap;
	pcr_state_e state, next_state;
	logic [31:0] cnt, next_cnt;
	logic [15:0] ctrl, next_ctrl;
	logic [15:0] adv, next_adv;
	logic [31:0] rdata, next_rdata;
	logic ack, next_ack;
	logic err, next_err;
	logic start_fire, next_start_fire;
	logic fail_q;
	logic first_done, next_first_done;
	logic [15:0] def_ctrl, def_adv;
	logic pin_ctl, req, hit, wr_ok;
	// cnt is shared by the blackout and the soft reset, which never overlap
	// fail_q holds the previous link failure level for edge detection

	// ---------------------------------------------------------------
	// strap capture
	// ---------------------------------------------------------------
	// the strap instance sees the raw reset so it latches on the release edge
	pcr_strap u_strap (
		.clk_in(CLK_IN),
		.reset_in(RESET_IN),
		.pins_in(LED_CONFIG_PIN_IN),
		.strap_out(strap)
	);

	// map strap pins to control defaults
	// pin1 high forces the speed bit to 100 so negotiation starts from the top
	// pin2 alone chooses the forced speed when negotiation is off
	function automatic logic [15:0] strap_ctrl(input logic [2:0] p);
		logic [15:0] c;
		c = 16'h0000;
		c[B_ANEG] = p[0];
		c[B_SPEED] = p[0] | p[1];
		c[B_FDX] = p[2];
		return c;
	endfunction

	// map strap pins to advertisement defaults
	function automatic logic [15:0] strap_adv(input logic [2:0] p);
		logic [15:0] a;
		a = ADV_RESET;
		if (p[0]) begin
			a[B_A100H] = 1'b1;
			a[B_A100F] = p[2];
			a[B_A10H] = p[1];
			a[B_A10F] = p[1] & p[2];
		end
		return a;
	endfunction

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	always_comb begin
		def_ctrl = strap_ctrl(strap);
		def_adv = strap_adv(strap);
	end
	assign pin_ctl = MGMT_PORT_DISABLE_PIN_IN;
	assign req = WB_CYC_IN && WB_STB_IN && !ack && !err;
	assign hit = (WB_ADR_IN == OFS_CTRL) || (WB_ADR_IN == OFS_ADV) ||
		(WB_ADR_IN == OFS_STAT) || (WB_ADR_IN == OFS_STRAP);
	// status and strap words decode as hits so reads succeed; their writes are
	// acked and dropped, which keeps software polling loops free of error paths
	// writes need managed mode, no power-down and no blackout
	assign wr_ok = !pin_ctl && !POWER_DOWN_PIN_IN && (state != PCR_HOLD);

	// ---------------------------------------------------------------
	// state machine, registers and bus answers
	// ---------------------------------------------------------------
	// the status word is answered even in blackout so software can poll readiness; power-down refuses it too
	// hold: blackout after hardware reset; ctrl and adv follow the latched straps
	// so that the first value software sees is already the strap default
	// run: normal service; link failure edges and mode bit changes relaunch the port
	// soft reset: straps restored, never resampled, reset bit reads one meanwhile
	// down: power-down pin high; the bus is refused and no start pulse goes out
	// writes land only in run, so a soft reset cannot be cut short by a write
	// limitation: a start pulse in the first run cycle may be followed by a link
	// failure pulse; the link logic beyond must accept back-to-back starts
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_ctrl = ctrl;
		next_adv = adv;
		next_rdata = rdata;
		next_ack = 1'b0;
		next_err = 1'b0;
		next_start_fire = 1'b0;
		next_first_done = first_done;
		case (state)
			PCR_HOLD: begin
				next_ctrl = def_ctrl;
				next_adv = def_adv;
				if (cnt >= HOLD_CYC - 1) begin
					next_state = PCR_RUN;
					next_cnt = 32'h00000000;
					next_start_fire = 1'b1;
				end else begin
					next_cnt = cnt + 32'h00000001;
				end
			end
			PCR_RUN: begin
				if (POWER_DOWN_PIN_IN) begin
					next_state = PCR_DOWN;
				end else if (!fail_q && LINK_FAIL_IN) begin
					next_start_fire = 1'b1;
				end
			end
			PCR_SRST: begin
				next_ctrl = def_ctrl;
				next_ctrl[B_SRST] = 1'b1;
				next_adv = def_adv;
				if (cnt >= SRST_CYC - 1) begin
					next_ctrl[B_SRST] = 1'b0;
					next_state = PCR_RUN;
					next_cnt = 32'h00000000;
					next_start_fire = 1'b1;
				end else begin
					next_cnt = cnt + 32'h00000001;
				end
			end
			PCR_DOWN: begin
				if (!POWER_DOWN_PIN_IN) begin
					next_state = PCR_RUN;
					next_start_fire = 1'b1;
				end
			end
			default: begin
				next_state = PCR_HOLD;
				next_cnt = 32'h00000000;
			end
		endcase
		if (!first_done && state == PCR_RUN) begin
			next_first_done = 1'b1;
		end
		// bus transfer: refused entirely while powered down
		if (req) begin
			if (!hit || POWER_DOWN_PIN_IN || (state == PCR_HOLD && WB_ADR_IN != OFS_STAT)) begin
				next_err = 1'b1;
			end else begin
				next_ack = 1'b1;
				next_rdata = 32'h00000000;
				case (WB_ADR_IN)
					OFS_CTRL: next_rdata[15:0] = ctrl;
					OFS_ADV: next_rdata[15:0] = adv;
					OFS_STAT: begin
						next_rdata[S_READY] = (state != PCR_HOLD);
						next_rdata[S_PINCTL] = pin_ctl;
						next_rdata[S_FORCED] = !ctrl[B_ANEG];
						next_rdata[S_ANRUN] = ctrl[B_ANEG];
						next_rdata[S_PORTUP] = PORT_ENABLE_OUT;
						next_rdata[S_SRST] = (state == PCR_SRST);
					end
					OFS_STRAP: next_rdata[2:0] = strap;
					default: next_rdata = 32'h00000000;
				endcase
				if (WB_WE_IN && wr_ok && state == PCR_RUN) begin
					if (WB_ADR_IN == OFS_CTRL) begin
						if (WB_SEL_IN[0]) begin
							next_ctrl[7:0] = WB_DAT_IN[7:0];
						end
						if (WB_SEL_IN[1]) begin
							next_ctrl[15:8] = WB_DAT_IN[15:8];
							if (WB_DAT_IN[B_SRST]) begin
								next_state = PCR_SRST;
								next_cnt = 32'h00000000;
							end
						end
						if (next_ctrl[B_ANEG] != ctrl[B_ANEG] ||
							next_ctrl[B_SPEED] != ctrl[B_SPEED] ||
							next_ctrl[B_FDX] != ctrl[B_FDX]) begin
							next_start_fire = 1'b1;
						end
					end else if (WB_ADR_IN == OFS_ADV) begin
						if (WB_SEL_IN[0]) begin
							next_adv[7:0] = WB_DAT_IN[7:0];
						end
						if (WB_SEL_IN[1]) begin
							next_adv[15:8] = WB_DAT_IN[15:8];
						end
					end
				end
			end
		end
	end

	// everything here is reset synchronously; the strap flops are kept apart
	// because they must capture exactly at reset release, not under reset
	// register all state
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			state <= PCR_HOLD;
			cnt <= 32'h00000000;
			ctrl <= 16'h0000;
			adv <= ADV_RESET;
			rdata <= 32'h00000000;
			ack <= 1'b0;
			err <= 1'b0;
			start_fire <= 1'b0;
			fail_q <= 1'b0;
			first_done <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ctrl <= next_ctrl;
			adv <= next_adv;
			rdata <= next_rdata;
			ack <= next_ack;
			err <= next_err;
			start_fire <= next_start_fire;
			fail_q <= LINK_FAIL_IN;
			first_done <= next_first_done;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// port runs only outside blackout, soft reset and both power-downs
	// start pulses are gated by the port enable, so a restart asked for during
	// soft power-down is dropped rather than held back for later; software
	// rewrites a mode bit after clearing bit 11 to relaunch the link
	always_comb begin
		PORT_ENABLE_OUT = (state == PCR_RUN) && !ctrl[B_SPD] && !POWER_DOWN_PIN_IN;
		FORCED_START_OUT = start_fire && !ctrl[B_ANEG] && PORT_ENABLE_OUT;
		ANEG_START_OUT = start_fire && ctrl[B_ANEG] && PORT_ENABLE_OUT;
		SPEED_100_OUT = ctrl[B_SPEED];
		FULL_DUPLEX_OUT = ctrl[B_FDX];
		CLOCK_RUN_OUT = !POWER_DOWN_PIN_IN;
		OUTPUT_HIZ_OUT = POWER_DOWN_PIN_IN;
		PULLS_ENABLE_OUT = !POWER_DOWN_PIN_IN;
		WB_ACK_OUT = ack;
		WB_ERR_OUT = err;
		WB_DAT_OUT = rdata;
	end
endmodule
`default_nettype wire

// ==== sim/pcr_mgmt_model.sv ====
// management controller model: classic wishbone master
`timescale 1ns/1ns
`default_nettype none
module pcr_mgmt_model (
	input wire logic clk_in,
	input wire logic ack_in,
	input wire logic err_in,
	input wire logic [31:0] dat_in,
	output logic cyc_out,
	output logic stb_out,
	output logic we_out,
	output logic [7:0] adr_out,
	output logic [3:0] sel_out,
	output logic [31:0] dat_out
);
	initial {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
	// one access per call, paced by the bus clock; released lines show inverted data
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] q, output logic e);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= w;
		adr_out <= a;
		sel_out <= 4'h3;
		dat_out <= {16'h0000, d};
		do @(posedge clk_in); while (!(ack_in || err_in));
		q = dat_in;
		e = err_in;
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		adr_out <= ~a;
		dat_out <= ~{16'h0000, d};
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ==== sim/pcr_top_asserts.sv ====
// checker: bus answers, start pulses and power-down outputs
`timescale 1ns/1ns
`default_nettype none
module pcr_top_asserts (
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic POWER_DOWN_PIN_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_ACK_OUT,
	input wire logic WB_ERR_OUT,
	input wire logic PORT_ENABLE_OUT,
	input wire logic FORCED_START_OUT,
	input wire logic ANEG_START_OUT,
	input wire logic CLOCK_RUN_OUT,
	input wire logic OUTPUT_HIZ_OUT,
	input wire logic PULLS_ENABLE_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// a request is taken only while no answer is showing
	wire logic req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
	wire logic ans = WB_ACK_OUT || WB_ERR_OUT;
	wire logic go = FORCED_START_OUT || ANEG_START_OUT;
	property p_answer; req |=> ans && !(WB_ACK_OUT && WB_ERR_OUT); endproperty
	a_answer: assert property (p_answer) else $error("no single answer");
	property p_once; ans |=> !ans; endproperty
	a_once: assert property (p_once) else $error("answer too long");
	property p_cause; ans |-> $past(WB_CYC_IN && WB_STB_IN); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_refuse; req && POWER_DOWN_PIN_IN |=> WB_ERR_OUT; endproperty
	a_refuse: assert property (p_refuse) else $error("access in power-down");
	property p_off; POWER_DOWN_PIN_IN |-> OUTPUT_HIZ_OUT && !CLOCK_RUN_OUT
		&& !PULLS_ENABLE_OUT && !PORT_ENABLE_OUT; endproperty
	a_off: assert property (p_off) else $error("power-down outputs");
	property p_on; !POWER_DOWN_PIN_IN |-> !OUTPUT_HIZ_OUT && CLOCK_RUN_OUT; endproperty
	a_on: assert property (p_on) else $error("running outputs");
	property p_start; go |-> !(FORCED_START_OUT && ANEG_START_OUT) ##1 !go; endproperty
	a_start: assert property (p_start) else $error("start pulse");
	property p_quiet; POWER_DOWN_PIN_IN |-> !go; endproperty
	a_quiet: assert property (p_quiet) else $error("start in power-down");
endmodule
`default_nettype wire

// ==== sim/pcr_top_test.sv ====
// testbench: straps, resets, power-down and register access
`timescale 1ns/1ns
`default_nettype none
module pcr_top_test
	import pcr_pkg::*;
();
	logic clk = 1'b0, rst = 1'b1, pd = 1'b0, mdis = 1'b1, lf = 1'b0, clr = 1'b1;
	logic [2:0] pins = 3'h0, s;
	logic cyc, stb, we, ack, err, pen, fs, ast, spd, fdx, crun, hiz, pul, e, sf, sa;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, rd, q, ctl, adv;
	int n_fail = 0, checked = 0, cycles = 0;
	pcr_top #(.HOLD_CYC(20)) u_pcr_top (.CLK_IN(clk), .RESET_IN(rst), .LED_CONFIG_PIN_IN(pins),
		.POWER_DOWN_PIN_IN(pd), .MGMT_PORT_DISABLE_PIN_IN(mdis), .LINK_FAIL_IN(lf),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
		.WB_DAT_IN(wd), .WB_DAT_OUT(rd), .WB_ACK_OUT(ack), .WB_ERR_OUT(err),
		.PORT_ENABLE_OUT(pen), .FORCED_START_OUT(fs), .ANEG_START_OUT(ast), .SPEED_100_OUT(spd),
		.FULL_DUPLEX_OUT(fdx), .CLOCK_RUN_OUT(crun), .OUTPUT_HIZ_OUT(hiz), .PULLS_ENABLE_OUT(pul));
	pcr_mgmt_model u_pcr_mgmt_model (.clk_in(clk), .ack_in(ack), .err_in(err), .dat_in(rd),
		.cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wd));
	initial forever #20 clk = ~clk;
	// sticky start flags and a hang limit
	always @(posedge clk) begin
		sf <= !clr && (sf || fs);
		sa <= !clr && (sa || ast);
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end
	task automatic results();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		u_pcr_mgmt_model.xfer(w, a, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
		bus(1'b0, a, 16'h0000);
		chk(n, x, q);
	endtask
	// every strap pattern in pin control, then managed mode
	initial begin
		for (int p = 0; p < 8; p++) begin
			s = p[2:0];
			pins <= s;
			rst <= 1'b1;
			clr <= 1'b1;
			repeat (8) @(posedge clk);
			rst <= 1'b0;
			clr <= 1'b0;
			@(posedge clk);
			bus(1'b0, OFS_CTRL, 16'h0000);
			chk("blackout", 32'h1, {31'h0, e});
			for (int i = 0; i < 40 && q[S_READY] !== 1'b1; i++) bus(1'b0, OFS_STAT, 16'h0000);
			ctl = 32'h0;
			ctl[B_ANEG] = s[0];
			ctl[B_SPEED] = s[0] | s[1];
			ctl[B_FDX] = s[2];
			adv = 32'h1;
			adv[B_A100F] = s[2];
			adv[B_A100H] = 1'b1;
			adv[B_A10F] = s[1] & s[2];
			adv[B_A10H] = s[1];
			rdc(OFS_CTRL, ctl, "ctrl");
			if (s[0]) rdc(OFS_ADV, adv, "adv");
			rdc(OFS_STRAP, {29'h0, s}, "strap");
			chk("start", {30'h0, s[0], !s[0]}, {30'h0, sa, sf});
			chk("levels", {30'h0, ctl[B_SPEED], ctl[B_FDX]}, {30'h0, spd, fdx});
			bus(1'b1, OFS_CTRL, 16'h0000);
			rdc(OFS_CTRL, ctl, "pin ctrl write");
		end
		mdis <= 1'b0;
		pins <= 3'h0;
		@(posedge clk);
		bus(1'b1, OFS_CTRL, 16'h0100);
		rdc(OFS_CTRL, 32'h0100, "managed");
		chk("speed", 32'h0, {31'h0, spd});
		bus(1'b1, OFS_CTRL, 16'h8000);
		bus(1'b0, OFS_CTRL, 16'h0000);
		chk("srst busy", 32'h1, {31'h0, q[B_SRST]});
		for (int i = 0; i < 20 && q[B_SRST] !== 1'b0; i++) bus(1'b0, OFS_CTRL, 16'h0000);
		chk("srst ctrl", ctl, q);
		rdc(OFS_STRAP, 32'h7, "strap held");
		bus(1'b1, OFS_CTRL, 16'h3900);
		rdc(OFS_CTRL, 32'h3900, "soft pd");
		chk("port off", 32'h0, {31'h0, pen});
		bus(1'b1, OFS_CTRL, 16'h3100);
		chk("port on", 32'h1, {31'h0, pen});
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		lf <= 1'b1;
		repeat (3) @(posedge clk);
		chk("relink", 32'h1, {31'h0, sa});
		lf <= 1'b0;
		pd <= 1'b1;
		@(posedge clk);
		bus(1'b0, OFS_CTRL, 16'h0000);
		chk("pd refuse", 32'h1, {31'h0, e});
		chk("pd pins", 32'h2, {29'h0, crun, hiz, pul});
		pd <= 1'b0;
		@(posedge clk);
		bus(1'b0, 8'h10, 16'h0000);
		chk("unmapped", 32'h1, {31'h0, e});
		results();
	end
endmodule
bind pcr_top pcr_top_asserts u_pcr_top_asserts (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
	.POWER_DOWN_PIN_IN(POWER_DOWN_PIN_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
	.WB_ACK_OUT(WB_ACK_OUT), .WB_ERR_OUT(WB_ERR_OUT), .PORT_ENABLE_OUT(PORT_ENABLE_OUT),
	.FORCED_START_OUT(FORCED_START_OUT), .ANEG_START_OUT(ANEG_START_OUT),
	.CLOCK_RUN_OUT(CLOCK_RUN_OUT), .OUTPUT_HIZ_OUT(OUTPUT_HIZ_OUT),
	.PULLS_ENABLE_OUT(PULLS_ENABLE_OUT));
`default_nettype wire
